// ### common/pfa_cfg.svh
// constants for the program fetch and addressing block
`ifndef PFA_CFG_SVH
`define PFA_CFG_SVH
`define PFA_PC_W          13
`define PFA_INSTR_W       14
`define PFA_IMPL_AW       10
`define PFA_IMPL_WORDS    1024
`define PFA_RESET_VEC     13'h0000
`define PFA_INT_VEC       13'h0004
`define PFA_EE_AW         6
`define PFA_EE_WORDS      64
`define PFA_DATA_AW       8
`define PFA_DATA_W        8
`define PFA_CLK_DIV       4
`endif

// ### common/pfa_pkg.sv
// types for the program fetch and addressing block
`include "pfa_cfg.svh"
package pfa_pkg;
  typedef logic [`PFA_PC_W-1:0] pfa_pc_t;

  // program store bus
  typedef struct packed {
    logic                    req;
    logic [`PFA_IMPL_AW-1:0] addr;
  } pfa_prog_bus_t;

  // data store bus
  typedef struct packed {
    logic                    req;
    logic                    we;
    logic [`PFA_DATA_AW-1:0] addr;
    logic [`PFA_DATA_W-1:0]  wdata;
  } pfa_data_bus_t;

  // eeprom access bus
  typedef struct packed {
    logic                  req;
    logic                  we;
    logic [`PFA_EE_AW-1:0] addr;
    logic [`PFA_DATA_W-1:0] wdata;
  } pfa_ee_bus_t;

  typedef enum logic [1:0] {
    PFA_Q1 = 2'b00,
    PFA_Q2 = 2'b01,
    PFA_Q3 = 2'b10,
    PFA_Q4 = 2'b11
  } pfa_phase_t;
endpackage : pfa_pkg

// ### rtl/pfa_clkdiv.sv
// quarter-rate phase counter and instruction clock output
`timescale 1ns/1ps
module pfa_clkdiv (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  output pfa_pkg::pfa_phase_t    phase_o,
  output logic                   instr_clk_o
);
  import pfa_pkg::*;

  pfa_phase_t phase_q;
  logic       clk_q;

  // ==========================================
  // phase sequencer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= PFA_Q1;
      // clock is high in phases 0 and 1, so it leaves reset high
      clk_q   <= 1'b1;
    end else begin
      phase_q <= pfa_phase_t'(phase_q + 2'h1);
      clk_q   <= (phase_q == PFA_Q1) || (phase_q == PFA_Q4) ? 1'b1 : 1'b0;
    end
  end

  assign phase_o     = phase_q;
  assign instr_clk_o = clk_q;
endmodule : pfa_clkdiv

// ### rtl/pfa_core.sv
// program fetch and memory addressing core
`timescale 1ns/1ps
`include "pfa_cfg.svh"
module pfa_core (
  input  wire logic                         clk_i,
  input  wire logic                         resetn_i,
  input  wire logic                         master_clear_n_i,
  input  wire logic                         rc_mode_i,
  input  wire logic                         int_take_i,
  input  wire logic                         branch_i,
  input  wire pfa_pkg::pfa_pc_t             branch_target_i,
  input  wire logic [`PFA_INSTR_W-1:0]      prog_rdata_i,
  input  wire logic                         data_req_i,
  input  wire logic                         data_we_i,
  input  wire logic [`PFA_DATA_AW-1:0]      data_addr_i,
  input  wire logic [`PFA_DATA_W-1:0]       data_wdata_i,
  input  wire logic                         ee_req_i,
  input  wire logic                         ee_we_i,
  input  wire logic [`PFA_EE_AW-1:0]        ee_ptr_i,
  input  wire logic [`PFA_DATA_W-1:0]       ee_wdata_i,
  output pfa_pkg::pfa_pc_t                  pc_o,
  output pfa_pkg::pfa_prog_bus_t            prog_bus_o,
  output pfa_pkg::pfa_data_bus_t            data_bus_o,
  output pfa_pkg::pfa_ee_bus_t              ee_bus_o,
  output logic [`PFA_INSTR_W-1:0]           instr_o,
  output logic                              instr_valid_o,
  output logic                              osc_output_instr_clock_o
);
  import pfa_pkg::*;

  // ==========================================
  // overview
  // fetch and data traffic run on separate buses
  // one instruction spans four edges of the oscillator clock
  // counter, fetch address and word capture share one phase count
  // interrupt beats branch, and branch beats the plain step
  // the counter is thirteen bits, the store sees only ten
  // eeprom traffic carries only the six-bit pointer
  // the rc clock output follows the phase count
  // inputs are taken as synchronous to clk_i
  // no software-visible registers live here

  // ==========================================
  // reset combination
  // either source alone puts the whole block in reset
  // both are levels, so reset lasts while either stays low
  // clears are async, so outputs drop without waiting for an edge
  // release is taken on the next clock edge as normal
  logic rst_n;
  assign rst_n = resetn_i & master_clear_n_i;

  // ==========================================
  // instruction phase generator
  // one instruction takes four oscillator edges
  // phase 0: fetch address goes out on the program bus
  // phase 1: program store answers on the next edge
  // phase 2: spare, data and eeprom buses keep running
  // phase 3: word taken, counter steps to next address
  // the divider restarts at phase 0 after every reset
  pfa_phase_t phase;
  logic       instr_clk;

  // phase count and divided clock share the combined reset
  pfa_clkdiv u_clkdiv (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n),
    .phase_o     (phase),
    .instr_clk_o (instr_clk)
  );

  // fold a full address onto the implemented store
  // upper counter bits stay in the counter only
  function automatic logic [`PFA_IMPL_AW-1:0] pfa_fold(input pfa_pc_t a);
    pfa_fold = a[`PFA_IMPL_AW-1:0];
  endfunction : pfa_fold

  // step a counter value by one word
  // carry out of the top bit is dropped, so the count wraps
  function automatic pfa_pc_t pfa_step(input pfa_pc_t a);
    pfa_step = pfa_pc_t'(a + 13'h0001);
  endfunction : pfa_step

  // ==========================================
  // program counter next value
  // pc_q holds the address of the instruction in flight
  // it only moves on the phase 3 edge
  pfa_pc_t pc_q;
  pfa_pc_t pc_d;
  logic    cyc_end;
  logic    fetch_start;

  assign cyc_end     = (phase == PFA_Q4);
  assign fetch_start = (phase == PFA_Q1);

  // redirect sources and sequential next address
  logic    pc_redirect;
  pfa_pc_t pc_target;
  pfa_pc_t pc_seq;

  assign pc_redirect = int_take_i | branch_i;
  assign pc_target   = int_take_i ? `PFA_INT_VEC : branch_target_i;
  assign pc_seq      = pfa_step(pc_q);
  // counter holds except on the last phase edge
  // pc_d is what the counter takes on the next edge
  assign pc_d        = !cyc_end    ? pc_q :
                       pc_redirect ? pc_target :
                       pc_seq;

  // thirteen bits cover the whole 8K word space
  // reset vector is loaded by either reset source
  // counter, reset to vector zero
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= `PFA_RESET_VEC;
    end else begin
      pc_q <= pc_d;
    end
  end

  // ==========================================
  // program bus, independent of data bus
  pfa_prog_bus_t prog_q;
  logic [`PFA_INSTR_W-1:0] instr_q;
  logic                    ivalid_q;

  pfa_prog_bus_t           prog_d;

  // next fetch request, address folded to the store width
  // req pulses once per instruction, in the cycle after phase 0
  // store has one edge of latency, word stands until phase 3
  assign prog_d = '{req: fetch_start, addr: pfa_fold(pc_q)};

  // only ten low bits address the store
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prog_q   <= '0;
      instr_q  <= '0;
      ivalid_q <= 1'b0;
    end else begin
      prog_q   <= prog_d;
      ivalid_q <= cyc_end;
      // store answer stands from phase 2, taken at phase 3
      if (cyc_end) begin
        instr_q <= prog_rdata_i;
      end
    end
  end

  // ==========================================
  // data and eeprom buses, same cycle as fetch
  pfa_data_bus_t data_q;
  pfa_ee_bus_t   ee_q;
  pfa_data_bus_t data_d;
  pfa_ee_bus_t   ee_d;

  // requests are copied through one register each
  // no phase gating, so a data access never waits for a fetch
  assign data_d = '{req: data_req_i, we: data_we_i, addr: data_addr_i, wdata: data_wdata_i};
  // pointer is six bits wide, so 0h to 3Fh is all it reaches
  assign ee_d   = '{req: ee_req_i, we: ee_we_i, addr: ee_ptr_i, wdata: ee_wdata_i};

  // data bus owns its flops, nothing shared with fetch
  // a fetch and a data access can finish in one cycle
  // data access runs alongside fetch
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= '0;
    end else begin
      data_q <= data_d;
    end
  end

  // registered like the data bus, no extra wait
  // eeprom through 6-bit pointer
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ee_q <= '0;
    end else begin
      ee_q <= ee_d;
    end
  end

  // ==========================================
  // oscillator output pin
  logic osc_q;
  logic osc_d;

  // divider clock passed out only in rc mode, else held low
  // a flop here keeps the pin free of gating glitches
  // turning rc mode on mid-instruction may give one short pulse
  assign osc_d = rc_mode_i & instr_clk;

  // quarter-rate clock in rc mode only
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      osc_q <= 1'b0;
    end else begin
      osc_q <= osc_d;
    end
  end

  // ==========================================
  // outputs, each straight from a register
  assign pc_o                     = pc_q;
  assign prog_bus_o               = prog_q;
  assign data_bus_o               = data_q;
  assign ee_bus_o                 = ee_q;
  assign instr_o                  = instr_q;
  assign instr_valid_o            = ivalid_q;
  assign osc_output_instr_clock_o = osc_q;
endmodule : pfa_core

// ### verification/pfa_properties.sv
// assertions on the fetch core ports
`timescale 1ns/1ps
module pfa_properties (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic master_clear_n_i,
  input wire logic rc_mode_i,
  input wire logic int_take_i,
  input wire logic branch_i,
  input wire logic data_req_i,
  input wire logic [7:0] data_addr_i,
  input wire logic ee_req_i,
  input wire logic [5:0] ee_ptr_i,
  input wire pfa_pkg::pfa_pc_t pc_o,
  input wire pfa_pkg::pfa_prog_bus_t prog_bus_o,
  input wire pfa_pkg::pfa_data_bus_t data_bus_o,
  input wire pfa_pkg::pfa_ee_bus_t ee_bus_o,
  input wire logic osc_output_instr_clock_o
);
  import pfa_pkg::*;
  // ====
  // fetch core checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i || !master_clear_n_i);
  property p_fold; prog_bus_o.req |-> prog_bus_o.addr == pc_o[9:0]; endproperty
  a_fold: assert property (p_fold) else $error("fold");
  property p_rate; prog_bus_o.req |=> !prog_bus_o.req [*3] ##1 prog_bus_o.req; endproperty
  a_rate: assert property (p_rate) else $error("rate");
  property p_inc;
    $changed(pc_o) && !$past(int_take_i) && !$past(branch_i) |-> pc_o == $past(pc_o) + 13'h1;
  endproperty
  a_inc: assert property (p_inc) else $error("inc");
  property p_int; $changed(pc_o) && $past(int_take_i) |-> pc_o == 13'h0004; endproperty
  a_int: assert property (p_int) else $error("int");
  property p_osc;
    $rose(osc_output_instr_clock_o) && $past(rc_mode_i, 3) |=> osc_output_instr_clock_o
      ##1 !osc_output_instr_clock_o [*2] ##1 osc_output_instr_clock_o;
  endproperty
  a_osc: assert property (p_osc) else $error("osc");
  // requests seen while a reset is still sampled low are not registered
  property p_dt;
    data_req_i && resetn_i && master_clear_n_i |=> data_bus_o.req && data_bus_o.addr == $past(data_addr_i);
  endproperty
  a_dt: assert property (p_dt) else $error("data");
  property p_ee;
    ee_req_i && resetn_i && master_clear_n_i |=> ee_bus_o.req && ee_bus_o.addr == $past(ee_ptr_i);
  endproperty
  a_ee: assert property (p_ee) else $error("ee");
  property p_clr; disable iff (!resetn_i) !master_clear_n_i |-> pc_o == '0 && !prog_bus_o.req; endproperty
  a_clr: assert property (p_clr) else $error("clear");
endmodule : pfa_properties

// ### verification/pfa_prog_mem.sv
// behavioural program store
`timescale 1ns/1ps
module pfa_prog_mem (
  input  wire logic                   clk_i,
  input  wire pfa_pkg::pfa_prog_bus_t prog_bus_i,
  output logic [13:0]                 rdata_o
);
  import pfa_pkg::*;
  always @(posedge clk_i) begin
    if (prog_bus_i.req) rdata_o <= {prog_bus_i.addr[3:0] ^ 4'ha, prog_bus_i.addr};
  end
endmodule : pfa_prog_mem

// ### verification/tb_pfa_core.sv
// bench for the fetch and addressing core
`timescale 1ns/1ps
module tb_pfa_core;
  import pfa_pkg::*;
  logic clk_i = 0, resetn_i = 0, master_clear_n_i = 1, rc_mode_i = 0, int_take_i = 0, branch_i = 0;
  logic data_req_i = 0, data_we_i = 0, ee_req_i = 0, ee_we_i = 0, instr_valid_o, osc_output_instr_clock_o;
  logic [7:0] data_addr_i = '0, data_wdata_i = '0, ee_wdata_i = '0;
  logic [5:0] ee_ptr_i = '0;
  logic [13:0] prog_rdata_i, instr_o;
  pfa_pc_t branch_target_i = '0, exp_pc = '0, pc_o;
  pfa_prog_bus_t prog_bus_o;
  pfa_data_bus_t data_bus_o;
  pfa_ee_bus_t ee_bus_o;
  int error_cnt = 0, samples_checked = 0, seed = 7, n = 0;
  // ====
  // design and store
  pfa_core pfa_core_i (.*);
  pfa_prog_mem pfa_prog_mem_i (.clk_i(clk_i), .prog_bus_i(prog_bus_o), .rdata_o(prog_rdata_i));
  always #50 clk_i = ~clk_i;
  // expected counter after one instruction
  function automatic pfa_pc_t nxt(pfa_pc_t pc, logic it, logic br, pfa_pc_t tg);
    nxt = it ? 13'h0004 : br ? tg : pc + 13'h1;
  endfunction : nxt
  task automatic chk(input logic ok, input string what);
    samples_checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  // random bus traffic every cycle, new interrupt and branch operands per instruction
  always @(posedge clk_i) begin
    {data_req_i, data_we_i, data_addr_i, data_wdata_i, ee_req_i, ee_we_i, ee_ptr_i, ee_wdata_i}
      <= 34'({$random(seed), $random(seed)});
    if (instr_valid_o) begin
      n <= n + 1;
      rc_mode_i <= n > 20;
      int_take_i <= n != 5 && $random(seed) % 8 == 0;
      branch_i <= n == 5 || $random(seed) % 4 == 0;
      branch_target_i <= n == 5 ? 13'h1fff : 13'($random(seed));
    end
  end
  // word and counter at each instruction end
  always @(negedge clk_i) begin
    if (instr_valid_o === 1'b1) begin
      chk(instr_o === {exp_pc[3:0] ^ 4'ha, exp_pc[9:0]}, "word");
      exp_pc = nxt(exp_pc, int_take_i, branch_i, branch_target_i);
      chk(pc_o === exp_pc, "pc");
    end
  end
  // bus copies, instruction rate and rc clock shape, every cycle
  logic live = 0;
  logic [33:0] last_in = '0;
  logic [3:0] osc_hist = '0;
  int rc_cnt = 0, vgap = 0;
  always @(negedge clk_i) begin
    if (live && resetn_i && master_clear_n_i) begin
      chk(data_bus_o === last_in[33:16], "data bus");
      chk(ee_bus_o === last_in[15:0], "ee bus");
    end
    if (instr_valid_o === 1'b1 && vgap != 0) chk(vgap == 4, "valid rate");
    if (rc_mode_i !== 1'b1) chk(osc_output_instr_clock_o === 1'b0, "osc idle");
    else if (rc_cnt > 8 && resetn_i && master_clear_n_i)
      chk(osc_output_instr_clock_o === osc_hist[3] && $countones(osc_hist) == 2, "osc rate");
    live = resetn_i && master_clear_n_i;
    vgap = !live ? 0 : instr_valid_o === 1'b1 ? 1 : vgap != 0 ? vgap + 1 : 0;
    rc_cnt = live && rc_mode_i ? rc_cnt + 1 : 0;
    osc_hist = {osc_hist[2:0], osc_output_instr_clock_o};
    last_in = {data_req_i, data_we_i, data_addr_i, data_wdata_i, ee_req_i, ee_we_i, ee_ptr_i, ee_wdata_i};
  end
  initial begin
    repeat (20) @(posedge clk_i);
    resetn_i <= 1;
    @(negedge clk_i);
    chk(pc_o === '0 && prog_bus_o === '0, "reset");
    repeat (300) @(posedge clk_i);
    $display("run done");
    master_clear_n_i <= 0;
    repeat (3) @(negedge clk_i);
    chk(pc_o === '0, "clear");
    exp_pc = '0;
    @(posedge clk_i);
    master_clear_n_i <= 1;
    repeat (300) @(posedge clk_i);
    $display("clear done");
    results();
  end
  initial begin
    #100000;
    error_cnt++;
    results();
  end
endmodule : tb_pfa_core
bind pfa_core pfa_properties pfa_properties_i (.*);
